/* ctxb_defines.svh */
// ctxb_defines.svh: offsets, field widths and reset values of the transmit buffer control block
// assumes: included by bare name from the package and the design modules
`ifndef CTXB_DEFINES_SVH
`define CTXB_DEFINES_SVH

`define CTXB_ADDR_W 4
`define CTXB_DATA_W 8
`define CTXB_NBUF 3
// register offsets
`define CTXB_OFF_FLAG 4'h0
`define CTXB_OFF_IEN 4'h1
`define CTXB_OFF_ARQ 4'h2
`define CTXB_OFF_AAK 4'h3
`define CTXB_OFF_BSEL 4'h4
`define CTXB_OFF_CTRL 4'h5
// reset values
`define CTXB_RST_FLAG 3'h7
`define CTXB_RST_ZERO 3'h0
`define CTXB_RD_ZERO 8'h00
// control register bit positions
`define CTXB_CTRL_INIT_REQUEST 0
`define CTXB_CTRL_LISTEN 1
`define CTXB_CTRL_INIT_ACKNOWLEDGE 2

`endif

/* ctxb_pkg.sv */
// ctxb_pkg.sv: types shared by the transmit buffer control files
// assumes: ctxb_defines.svh is on the include path
`include "ctxb_defines.svh"

package ctxb_pkg;
  typedef logic [`CTXB_ADDR_W-1:0] ctxb_addr_t;
  typedef logic [`CTXB_DATA_W-1:0] ctxb_data_t;
  typedef logic [`CTXB_NBUF-1:0] ctxb_mask_t;
  // per-buffer transmit slot life cycle
  typedef enum logic [1:0] {CTXB_IDLE, CTXB_QUEUED, CTXB_SENDING} ctxb_slot_e;
endpackage : ctxb_pkg

/* ctxb_lowest.sv */
// ctxb_lowest.sv: isolates the lowest set bit of a vector
// assumes: purely combinational, used for the buffer select read and window mapping
`timescale 1ns/10ps
`include "ctxb_defines.svh"

module ctxb_lowest #(
  parameter int W = `CTXB_NBUF
) (
  input wire logic [W-1:0] vec,
  output logic [W-1:0] one_hot
);
  // x & -x keeps only the lowest set bit
  assign one_hot = vec & (~vec + {{(W-1){1'b0}}, 1'b1});
endmodule : ctxb_lowest

/* ctxb_slot.sv */
// ctxb_slot.sv: life cycle of one transmit buffer: empty flag, abort request and acknowledge
// assumes: protocol engine pulses start/done/fail; bus writes already decoded and gated
`timescale 1ns/10ps
`include "ctxb_defines.svh"

module ctxb_slot
  import ctxb_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic init_mode,
  input wire logic listen_only,
  input wire logic sched_wr,
  input wire logic abort_wr,
  input wire logic tx_start,
  input wire logic tx_done,
  input wire logic tx_fail,
  output logic empty,
  output logic abort_req,
  output logic abort_ack,
  output logic granted
);
  import ctxb_pkg::*;

  ctxb_slot_e state_reg;
  logic empty_reg;
  logic arq_reg;
  logic aak_reg;
  logic grant_now;

  // abort granted if not yet on the bus, or if the attempt just failed
  assign grant_now = arq_reg && !empty_reg &&
                     ((state_reg == CTXB_QUEUED && !tx_start) ||
                      (state_reg == CTXB_SENDING && tx_fail));
  assign granted = grant_now;

  // ----------------------------------------
  // slot sequence
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (srst || init_mode) begin
      state_reg <= CTXB_IDLE;
    end else if (ce) begin
      unique case (state_reg)
        CTXB_IDLE: begin
          if (sched_wr && !listen_only) begin
            state_reg <= CTXB_QUEUED;
          end
        end
        CTXB_QUEUED: begin
          if (grant_now) begin
            state_reg <= CTXB_IDLE;
          end else if (tx_start && !listen_only) begin
            state_reg <= CTXB_SENDING;
          end
        end
        CTXB_SENDING: begin
          if (tx_done || grant_now) begin
            state_reg <= CTXB_IDLE;
          end else if (tx_fail) begin
            state_reg <= CTXB_QUEUED;
          end
        end
      endcase
    end
  end

  // empty flag: set on success or abort, cleared by a scheduling write
  always_ff @(posedge mclk) begin
    if (srst || init_mode) begin
      empty_reg <= 1'b1;
    end else if (ce) begin
      if ((state_reg == CTXB_SENDING && tx_done) || grant_now) begin
        empty_reg <= 1'b1;
      end else if (sched_wr && !listen_only && empty_reg) begin
        empty_reg <= 1'b0;
      end
    end
  end

  // abort request: set by software only, cleared when the buffer turns empty
  always_ff @(posedge mclk) begin
    if (srst || init_mode) begin
      arq_reg <= 1'b0;
    end else if (ce) begin
      if ((state_reg == CTXB_SENDING && tx_done) || grant_now) begin
        arq_reg <= 1'b0;
      end else if (abort_wr && !empty_reg) begin
        arq_reg <= 1'b1;
      end
    end
  end

  // acknowledge: tells software whether the empty buffer was aborted
  always_ff @(posedge mclk) begin
    if (srst || init_mode) begin
      aak_reg <= 1'b0;
    end else if (ce) begin
      if (grant_now) begin
        aak_reg <= 1'b1;
      end else if (sched_wr && !listen_only && empty_reg) begin
        aak_reg <= 1'b0;
      end
    end
  end

  assign empty = empty_reg;
  assign abort_req = arq_reg;
  assign abort_ack = aak_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  arq_clear_a: assert property (@(posedge mclk) disable iff (srst)
    (ce && $rose(empty_reg)) |-> !arq_reg)
    else $error("abort request survived empty");
  aak_clear_a: assert property (@(posedge mclk) disable iff (srst)
    $fell(empty_reg) |-> !aak_reg)
    else $error("abort ack survived scheduling");
  grant_cond_a: assert property (@(posedge mclk) disable iff (srst)
    (ce && grant_now && !init_mode) |=> (empty_reg && aak_reg && !arq_reg))
    else $error("grant did not empty and acknowledge");
  done_ack_a: assert property (@(posedge mclk) disable iff (srst)
    (ce && !init_mode && state_reg == CTXB_SENDING && tx_done && !grant_now) |=>
    (empty_reg && !aak_reg))
    else $error("sent message shows aborted");
  listen_hold_a: assert property (@(posedge mclk) disable iff (srst)
    (listen_only && empty_reg) |=> empty_reg)
    else $error("empty flag cleared in listen mode");
endmodule : ctxb_slot

/* ctxb_ctrl.sv */
// ctxb_ctrl.sv: transmit buffer control top: registers, three slots, window select, irq
// assumes: single clock mclk; protocol engine gives per-buffer start/done/fail pulses
`timescale 1ns/10ps
`include "ctxb_defines.svh"

module ctxb_ctrl
  import ctxb_pkg::*;
#(
  parameter int NBUF = `CTXB_NBUF
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire ctxb_pkg::ctxb_addr_t addr,
  input wire ctxb_pkg::ctxb_data_t wdata,
  input wire logic wr,
  input wire logic rd,
  output ctxb_pkg::ctxb_data_t rdata,
  input wire logic init_acknowledge,
  input wire logic [NBUF-1:0] tx_start,
  input wire logic [NBUF-1:0] tx_done,
  input wire logic [NBUF-1:0] tx_fail,
  input wire logic win_req,
  output logic init_request,
  output logic listen_only,
  output logic [NBUF-1:0] buffer_empty_flag,
  output logic [NBUF-1:0] win_sel,
  output logic win_grant,
  output logic tx_irq
);
  import ctxb_pkg::*;

  // ----------------------------------------
  // mode and decode
  // ----------------------------------------
  logic init_request_reg;
  logic listen_reg;
  logic init_mode;
  logic wr_ok;
  logic [NBUF-1:0] ien_reg;
  logic [NBUF-1:0] bsel_reg;
  logic [NBUF-1:0] bsel_low;
  logic [NBUF-1:0] arq;
  logic [NBUF-1:0] aak;
  logic [NBUF-1:0] empty;
  logic [NBUF-1:0] granted;
  ctxb_data_t rdata_reg;
  ctxb_data_t rd_next;

  assign init_mode = init_request_reg && init_acknowledge;
  // writes other than to the control register blocked during init mode, reads are not
  assign wr_ok = wr && !init_mode;

  // init and listen controls are software's own; never held in reset by init mode
  always_ff @(posedge mclk) begin
    if (srst) begin
      init_request_reg <= 1'b0;
      listen_reg <= 1'b0;
    end else if (ce && wr && addr == `CTXB_OFF_CTRL) begin
      init_request_reg <= wdata[`CTXB_CTRL_INIT_REQUEST];
      listen_reg <= wdata[`CTXB_CTRL_LISTEN];
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (srst || init_mode) begin
      ien_reg <= `CTXB_RST_ZERO;
    end else if (ce && wr_ok && addr == `CTXB_OFF_IEN) begin
      ien_reg <= wdata[NBUF-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || init_mode) begin
      bsel_reg <= `CTXB_RST_ZERO;
    end else if (ce && wr_ok && addr == `CTXB_OFF_BSEL) begin
      bsel_reg <= wdata[NBUF-1:0];
    end
  end

  ctxb_lowest #(
    .W(NBUF)
  ) u_lowest (
    .vec(bsel_reg),
    .one_hot(bsel_low)
  );

  // ----------------------------------------
  // buffer slots
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NBUF; gi++) begin : g_slot
      ctxb_slot u_slot (
        .mclk(mclk),
        .srst(srst),
        .ce(ce),
        .init_mode(init_mode),
        .listen_only(listen_reg),
        .sched_wr(wr_ok && addr == `CTXB_OFF_FLAG && wdata[gi]),
        .abort_wr(wr_ok && addr == `CTXB_OFF_ARQ && wdata[gi]),
        .tx_start(tx_start[gi] && !listen_reg),
        .tx_done(tx_done[gi]),
        .tx_fail(tx_fail[gi]),
        .empty(empty[gi]),
        .abort_req(arq[gi]),
        .abort_ack(aak[gi]),
        .granted(granted[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // read path: data one cycle after the strobe
  // ----------------------------------------
  always_comb begin
    rd_next = `CTXB_RD_ZERO;
    unique case (addr)
      `CTXB_OFF_FLAG: rd_next[NBUF-1:0] = empty;
      `CTXB_OFF_IEN: rd_next[NBUF-1:0] = ien_reg;
      `CTXB_OFF_ARQ: rd_next[NBUF-1:0] = arq;
      `CTXB_OFF_AAK: rd_next[NBUF-1:0] = aak;
      `CTXB_OFF_BSEL: rd_next[NBUF-1:0] = bsel_low;
      `CTXB_OFF_CTRL: begin
        rd_next[`CTXB_CTRL_INIT_REQUEST] = init_request_reg;
        rd_next[`CTXB_CTRL_LISTEN] = listen_reg;
        rd_next[`CTXB_CTRL_INIT_ACKNOWLEDGE] = init_acknowledge;
      end
      default: rd_next = `CTXB_RD_ZERO;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_reg <= `CTXB_RD_ZERO;
    end else if (ce) begin
      rdata_reg <= rd ? rd_next : `CTXB_RD_ZERO;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rdata = rdata_reg;
  assign init_request = init_request_reg;
  assign listen_only = listen_reg;
  assign buffer_empty_flag = empty;
  assign win_sel = bsel_low;
  // a scheduled buffer or an empty selection closes the window
  assign win_grant = win_req && |(bsel_low & empty);
  // level irq: pends as long as any enabled empty flag stays set
  assign tx_irq = |(empty & ien_reg);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  init_hold_a: assert property (@(posedge mclk) disable iff (srst)
    (ce && init_mode) |=> (ien_reg == '0 && bsel_reg == '0 && arq == '0 && aak == '0))
    else $error("registers not held in init mode");
  init_wr_a: assert property (@(posedge mclk) disable iff (srst)
    (init_mode && wr && addr == `CTXB_OFF_IEN) |=> ien_reg == '0)
    else $error("enable written in init mode");
  irq_gate_a: assert property (@(posedge mclk) disable iff (srst)
    (ce && !init_mode && |(granted & ien_reg) && !(wr && addr == `CTXB_OFF_IEN)) |=> tx_irq)
    else $error("granted abort raised no irq");
  arq_sticky_a: assert property (@(posedge mclk) disable iff (srst)
    (ce && !init_mode && wr && addr == `CTXB_OFF_ARQ && granted == '0 && tx_done == '0) |=>
    ((arq & $past(arq)) == $past(arq)))
    else $error("abort request cleared by write");
  bsel_read_a: assert property (@(posedge mclk) disable iff (srst)
    (ce && rd && addr == `CTXB_OFF_BSEL) |=> $onehot0(rdata) && rdata[NBUF-1:0] ==
    $past(bsel_low))
    else $error("select read not lowest bit");
  aak_ro_a: assert property (@(posedge mclk) disable iff (srst)
    (ce && wr && addr == `CTXB_OFF_AAK && !init_mode && granted == '0) |=> $stable(aak))
    else $error("acknowledge changed by write");
  win_block_a: assert property (@(posedge mclk) disable iff (srst)
    (bsel_low == '0 || (bsel_low & empty) == '0) |-> !win_grant)
    else $error("window open to scheduled buffer");
  rd_upper_a: assert property (@(posedge mclk) disable iff (srst)
    rdata[`CTXB_DATA_W-1:NBUF] == '0)
    else $error("upper bits read nonzero");

  abort_cv: cover property (@(posedge mclk) disable iff (srst) |granted);
  send_cv: cover property (@(posedge mclk) disable iff (srst) $rose(empty[1]) && !aak[1]);
  win_cv: cover property (@(posedge mclk) disable iff (srst) win_grant && bsel_reg == 3'h6);
  init_cv: cover property (@(posedge mclk) disable iff (srst) $rose(init_mode));
endmodule : ctxb_ctrl

/* ctxb_engine_model.sv */
// ctxb_engine_model.sv: stand-in for the protocol engine beside the transmit control block
// assumes: one clock mclk; the bench commands each start, done and fail pulse
`timescale 1ns/10ps
module ctxb_engine_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic init_request,
  input wire logic listen_only,
  input wire logic [2:0] cmd_start,
  input wire logic [2:0] cmd_done,
  input wire logic [2:0] cmd_fail,
  output logic init_acknowledge,
  output logic [2:0] tx_start,
  output logic [2:0] tx_done,
  output logic [2:0] tx_fail
);
  // ack lags the request by one edge, so init mode starts late
  always_ff @(posedge mclk) begin
    init_acknowledge <= srst ? 1'b0 : init_request;
  end
  // a listening engine starts nothing
  always_ff @(posedge mclk) begin
    tx_start <= srst ? 3'h0 : cmd_start & {3{~listen_only}};
    tx_done <= srst ? 3'h0 : cmd_done;
    tx_fail <= srst ? 3'h0 : cmd_fail;
  end
endmodule : ctxb_engine_model

/* can_tx_buffer_control_tb_top.sv */
// can_tx_buffer_control_tb_top.sv: self-checking bench of the transmit buffer control block
// assumes: ctxb_pkg compiled first; engine model drives the per-buffer pulses
`timescale 1ns/10ps
`include "ctxb_defines.svh"
module can_tx_buffer_control_tb_top;
  import ctxb_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  ctxb_addr_t addr = 4'h0;
  ctxb_data_t wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic win_req = 1'b0;
  logic [2:0] cmd_start = 3'h0, cmd_done = 3'h0, cmd_fail = 3'h0;
  ctxb_data_t rdata;
  logic init_acknowledge, init_request, listen_only, win_grant, tx_irq;
  logic [2:0] tx_start, tx_done, tx_fail, buffer_empty_flag, win_sel;
  int miscompares = 0;
  int check_count = 0;
  logic [31:0] rnd = 32'h8BF0D766;
  // ---------------------------------------------------------------
  // bench model of the register state
  // ---------------------------------------------------------------
  logic [2:0] m_empty = 3'h7, m_ien = 3'h0, m_arq = 3'h0, m_aak = 3'h0;
  logic [2:0] m_bsel = 3'h0, m_send = 3'h0;
  logic [1:0] m_ctrl = 2'h0;

  ctxb_ctrl #(.NBUF(3)) dut (.mclk(mclk), .srst(srst), .ce(1'b1), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .init_acknowledge(init_acknowledge),
    .tx_start(tx_start), .tx_done(tx_done), .tx_fail(tx_fail), .win_req(win_req),
    .init_request(init_request), .listen_only(listen_only),
    .buffer_empty_flag(buffer_empty_flag), .win_sel(win_sel), .win_grant(win_grant),
    .tx_irq(tx_irq));
  ctxb_engine_model eng (.mclk(mclk), .srst(srst), .init_request(init_request),
    .listen_only(listen_only), .cmd_start(cmd_start), .cmd_done(cmd_done),
    .cmd_fail(cmd_fail), .init_acknowledge(init_acknowledge), .tx_start(tx_start),
    .tx_done(tx_done), .tx_fail(tx_fail));

  initial begin
    forever #4 mclk = ~mclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic logic [2:0] low1(input logic [2:0] b);
    return b & (~b + 3'h1);
  endfunction : low1

  function automatic logic [7:0] exp_reg(input logic [3:0] a);
    case (a)
      `CTXB_OFF_FLAG: return {5'h00, m_empty};
      `CTXB_OFF_IEN: return {5'h00, m_ien};
      `CTXB_OFF_ARQ: return {5'h00, m_arq};
      `CTXB_OFF_AAK: return {5'h00, m_aak};
      `CTXB_OFF_BSEL: return {5'h00, low1(m_bsel)};
      `CTXB_OFF_CTRL: return {5'h00, m_ctrl[0], m_ctrl};
      default: return 8'h00;
    endcase
  endfunction : exp_reg

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic cmp_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp_reg

  task automatic cmp_pin(input string name, input logic [2:0] exp, input logic [2:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp_pin

  task automatic chk_pins;
    cmp_pin("empty", m_empty, buffer_empty_flag);
    cmp_pin("irq", {2'h0, |(m_empty & m_ien)}, {2'h0, tx_irq});
    cmp_pin("win_sel", low1(m_bsel), win_sel);
    cmp_pin("grant", {2'h0, win_req & |(low1(m_bsel) & m_empty)}, {2'h0, win_grant});
    cmp_pin("mode", {1'b0, m_ctrl}, {1'b0, listen_only, init_request});
  endtask : chk_pins

  task automatic rd_chk(input logic [3:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 cmp_reg($sformatf("reg %0h", a), exp_reg(a), rdata);
  endtask : rd_chk

  task automatic rd_all;
    for (int a = 0; a < 6; a++) rd_chk(a[3:0]);
    rd_chk(4'hF);
  endtask : rd_all

  // writes land after two edges so an immediate abort grant is seen too
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    logic [2:0] g;
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    win_req <= ~win_req;
    @(posedge mclk);
    wr <= 1'b0;
    if (a == `CTXB_OFF_CTRL) m_ctrl = d[1:0];
    else if (!m_ctrl[0]) begin
      case (a)
        `CTXB_OFF_FLAG: if (!m_ctrl[1]) begin
          m_aak &= ~d[2:0];
          m_empty &= ~d[2:0];
        end
        `CTXB_OFF_IEN: m_ien = d[2:0];
        `CTXB_OFF_ARQ: m_arq |= d[2:0] & ~m_empty;
        `CTXB_OFF_BSEL: m_bsel = d[2:0];
        default: ;
      endcase
    end
    g = m_arq & ~m_send;
    m_empty |= g;
    m_aak |= g;
    m_arq &= ~g;
    if (m_ctrl[0]) begin
      {m_ien, m_arq, m_aak, m_bsel, m_send} = 15'h0;
      m_empty = 3'h7;
    end
    // init mode needs the engine's acknowledge edge before the reset lands
    if (a == `CTXB_OFF_CTRL) @(posedge mclk);
    @(posedge mclk);
    #1 chk_pins();
  endtask : wr_reg

  // kind 0 start, 1 done, 2 fail
  task automatic pulse(input int k, input logic [2:0] m);
    logic [2:0] g;
    @(posedge mclk);
    if (k == 0) cmd_start <= m;
    else if (k == 1) cmd_done <= m;
    else cmd_fail <= m;
    @(posedge mclk);
    {cmd_start, cmd_done, cmd_fail} <= 9'h0;
    @(posedge mclk);
    g = m & m_send;
    if (k == 0 && !m_ctrl[1]) m_send |= m & ~m_empty;
    if (k == 1) begin
      m_empty |= g;
      m_aak &= ~g;
      m_arq &= ~g;
    end
    if (k != 0) m_send &= ~g;
    if (k == 2) begin
      g &= m_arq;
      m_empty |= g;
      m_aak |= g;
      m_arq &= ~g;
    end
    #1 chk_pins();
  endtask : pulse

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    rd_all();
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      wr_reg(`CTXB_OFF_IEN, rnd[7:0]);
      wr_reg(`CTXB_OFF_BSEL, rnd[15:8]);
      rd_chk(`CTXB_OFF_BSEL);
      rd_chk(`CTXB_OFF_IEN);
    end
    wr_reg(`CTXB_OFF_BSEL, 8'h00);
    wr_reg(`CTXB_OFF_FLAG, 8'h00);
    wr_reg(`CTXB_OFF_FLAG, 8'h01);
    wr_reg(`CTXB_OFF_BSEL, {5'h00, m_empty});
    rd_chk(`CTXB_OFF_BSEL);
    wr_reg(`CTXB_OFF_BSEL, 8'h07);
    wr_reg(`CTXB_OFF_IEN, 8'h07);
    wr_reg(`CTXB_OFF_ARQ, 8'h01);
    wr_reg(`CTXB_OFF_AAK, 8'h00);
    rd_all();
    wr_reg(`CTXB_OFF_FLAG, 8'h03);
    rd_chk(`CTXB_OFF_AAK);
    pulse(0, 3'h2);
    wr_reg(`CTXB_OFF_ARQ, 8'h02);
    wr_reg(`CTXB_OFF_ARQ, 8'h00);
    rd_chk(`CTXB_OFF_ARQ);
    pulse(1, 3'h2);
    rd_all();
    pulse(0, 3'h1);
    wr_reg(`CTXB_OFF_ARQ, 8'h01);
    pulse(2, 3'h1);
    rd_all();
    wr_reg(`CTXB_OFF_CTRL, 8'h02);
    wr_reg(`CTXB_OFF_FLAG, 8'h07);
    pulse(0, 3'h7);
    rd_all();
    wr_reg(`CTXB_OFF_CTRL, 8'h00);
    wr_reg(`CTXB_OFF_FLAG, 8'h01);
    wr_reg(`CTXB_OFF_CTRL, 8'h01);
    wr_reg(`CTXB_OFF_IEN, 8'h07);
    wr_reg(`CTXB_OFF_BSEL, 8'h07);
    wr_reg(`CTXB_OFF_ARQ, 8'h07);
    rd_all();
    wr_reg(`CTXB_OFF_CTRL, 8'h00);
    wr_reg(`CTXB_OFF_IEN, 8'h05);
    rd_all();
    stop_test();
  end
endmodule : can_tx_buffer_control_tb_top
